// File: rtl/rod_pkg.sv
// rod_pkg: constants and types for the signal level and threshold demodulator
package rod_pkg;
	// ****************************************
	// register offsets (plain address space)
	// ****************************************
	localparam logic [3:0] ADDR_READOUT = 4'h0;
	localparam logic [3:0] ADDR_DEVIATION = 4'h1;
	localparam logic [3:0] ADDR_IRQ_THRESH = 4'h2;
	localparam logic [3:0] ADDR_FLOOR = 4'h3;
	localparam logic [3:0] ADDR_IRQ_FLAG = 4'h4;
	localparam logic [3:0] ADDR_IRQ_SRC = 4'h5;
	localparam logic [3:0] ADDR_DEMOD = 4'h6;
	localparam logic [3:0] ADDR_OOK_CFG = 4'h7;
	// ****************************************
	// field positions
	// ****************************************
	localparam int FLAG_BIT = 2;
	localparam int SRC0_LSB = 6;
	localparam int SRC1_LSB = 4;
	localparam int TYPE_LSB = 3;
	localparam int FSK_BIT = 5;
	localparam int STEP_LSB = 5;
	localparam int PER_LSB = 2;
	// ****************************************
	// reset values and constants
	// ****************************************
	localparam logic [7:0] DEV_RESET = 8'h03;
	localparam logic [7:0] THRESH_RESET = 8'h00;
	localparam logic [7:0] FLOOR_RESET = 8'h0C;
	localparam logic [7:0] DEMOD_RESET = 8'h00;
	localparam logic [7:0] OOK_RESET = 8'h00;
	localparam logic [1:0] SRC_LEVEL = 2'h1;
	localparam int SAMPLES = 16;
	localparam logic [7:0] PEAK_DROP = 8'h0C;
	localparam int CHIP_SAMPLES = 16;

	typedef enum logic [1:0] {
		ROD_TH_PEAK = 2'b00,
		ROD_TH_FIXED = 2'b01,
		ROD_TH_AVG = 2'b10
	} rod_th_t;

	// step in half-dB units per code
	function automatic logic [7:0] rod_step(input logic [2:0] code);
		case (code)
			3'h0: rod_step = 8'h01;
			3'h1: rod_step = 8'h02;
			3'h2: rod_step = 8'h03;
			3'h3: rod_step = 8'h04;
			3'h4: rod_step = 8'h06;
			3'h5: rod_step = 8'h08;
			3'h6: rod_step = 8'h0A;
			default: rod_step = 8'h0C;
		endcase
	endfunction : rod_step

	function automatic logic [7:0] rod_sat_sub(input logic [7:0] a,
		input logic [7:0] b);
		rod_sat_sub = (a > b) ? a - b : 8'h00;
	endfunction : rod_sat_sub
endpackage : rod_pkg

// File: rtl/rod_level_if.sv
// rod_level_if: level samples passed between the estimator and the top
`timescale 1ns/1ps
`default_nettype none
interface rod_level_if;
	logic sample_stb;
	logic [7:0] level;
	logic level_stb;
	modport est (input sample_stb, output level, output level_stb);
	modport top (output sample_stb, input level, input level_stb);
endinterface : rod_level_if
`default_nettype wire

// File: rtl/rod_level_est.sv
// rod_level_est: sixteen-sample sliding average of baseband magnitude
`timescale 1ns/1ps
`default_nettype none
module rod_level_est
	import rod_pkg::*;
#(
	parameter int DEPTH = SAMPLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] mag,
	rod_level_if.est lv
);
	logic [7:0] win_reg [DEPTH];
	logic [11:0] sum_reg;
	logic [3:0] wp_reg;
	logic [7:0] level_reg;
	logic stb_reg;
	wire logic [11:0] sum_next = sum_reg + 12'(mag) - 12'(win_reg[wp_reg]);

	assign lv.level = level_reg;
	assign lv.level_stb = stb_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) win_reg[i] <= 8'h00;
			sum_reg <= 12'h000;
			wp_reg <= 4'h0;
			level_reg <= 8'h00;
			stb_reg <= 1'b0;
		end else if (ce) begin
			stb_reg <= lv.sample_stb;
			if (lv.sample_stb) begin
				win_reg[wp_reg] <= mag;
				sum_reg <= sum_next;
				wp_reg <= wp_reg + 4'h1;
				level_reg <= sum_next[11:4];
			end
		end
	end
endmodule : rod_level_est
`default_nettype wire

// File: rtl/rod_sample_gen.sv
// rod_sample_gen: sample strobe at sixteen times the deviation frequency
`timescale 1ns/1ps
`default_nettype none
module rod_sample_gen
	import rod_pkg::*;
#(
	parameter int ACC_W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] deviation,
	output logic stb
);
	logic [ACC_W-1:0] acc_reg;
	wire logic [ACC_W:0] acc_sum = {1'b0, acc_reg} + (ACC_W+1)'({deviation, 4'h0});

	always_ff @(posedge clk) begin
		if (rst) begin
			acc_reg <= '0;
			stb <= 1'b0;
		end else if (ce) begin
			acc_reg <= acc_sum[ACC_W-1:0];
			stb <= acc_sum[ACC_W];
		end
	end
endmodule : rod_sample_gen
`default_nettype wire

// File: rtl/rod_top.sv
// rod_top: signal level estimator, level interrupt and ook/fsk demodulator
`timescale 1ns/1ps
`default_nettype none
// Contract
// - ook: sixteen samples per second if period
// - fsk: sixteen samples per deviation period
// - average over sliding sixteen samples
// - level register updates every sample
// - level lsb equals half decibel
// - level above limit sets irq flag
// - flag bit two, write one clears
// - source selectors route flag to pins
// - ook data: level versus threshold
// - type field selects three schemes
// - peak threshold is peak minus six dB
// - peak decays by step each period (code: only while ook_next is low)
// - decay stops at floor threshold
// - deviation sets sampling frequencies
// - fsk data from i/q relative phase
// - raw fsk output in continuous mode
// - period field: chip multiples or fractions
// - step field: half to six dB
// - fixed floor and averaged thresholds
module rod_top
	import rod_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] i_in,
	input wire logic [7:0] q_in,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic first_interrupt_pin,
	output logic second_interrupt_pin,
	output logic ook_data,
	output logic fsk_raw_data
);
	// ****************************************
	// input synchronisers
	// ****************************************
	logic [7:0] i_s1_reg, i_s2_reg, q_s1_reg, q_s2_reg;
	always_ff @(posedge clk) begin
		if (rst) begin
			i_s1_reg <= 8'h00;
			i_s2_reg <= 8'h00;
			q_s1_reg <= 8'h00;
			q_s2_reg <= 8'h00;
		end else if (ce) begin
			i_s1_reg <= i_in;
			i_s2_reg <= i_s1_reg;
			q_s1_reg <= q_in;
			q_s2_reg <= q_s1_reg;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	logic [7:0] deviation_setting_reg;
	logic [7:0] signal_level_irq_threshold_reg;
	logic [7:0] ook_floor_level_reg;
	logic [7:0] irq_source_config_register_reg;
	logic [7:0] demodulation_config_register_reg;
	logic [7:0] ook_config_register_reg;
	logic signal_level_irq_flag_reg;
	logic [7:0] signal_level_readout_reg;

	wire logic [7:0] deviation_value = deviation_setting_reg;
	wire logic [7:0] signal_level_irq_limit = signal_level_irq_threshold_reg;
	wire logic [7:0] floor_threshold_value = ook_floor_level_reg;
	wire logic [1:0] first_pin_rx_source_sel =
		irq_source_config_register_reg[SRC0_LSB +: 2];
	wire logic [1:0] second_pin_rx_source_sel =
		irq_source_config_register_reg[SRC1_LSB +: 2];
	wire logic [1:0] ook_threshold_type =
		demodulation_config_register_reg[TYPE_LSB +: 2];
	wire logic fsk_mode = demodulation_config_register_reg[FSK_BIT];
	wire logic [2:0] ook_decay_step = ook_config_register_reg[STEP_LSB +: 3];
	wire logic [2:0] ook_decay_period = ook_config_register_reg[PER_LSB +: 3];

	wire logic wr_dev = reg_wr && reg_addr == ADDR_DEVIATION;
	wire logic wr_thr = reg_wr && reg_addr == ADDR_IRQ_THRESH;
	wire logic wr_flr = reg_wr && reg_addr == ADDR_FLOOR;
	wire logic wr_flag = reg_wr && reg_addr == ADDR_IRQ_FLAG;
	wire logic wr_src = reg_wr && reg_addr == ADDR_IRQ_SRC;
	wire logic wr_dmd = reg_wr && reg_addr == ADDR_DEMOD;
	wire logic wr_ook = reg_wr && reg_addr == ADDR_OOK_CFG;

	always_ff @(posedge clk) begin
		if (rst) begin
			deviation_setting_reg <= DEV_RESET;
			signal_level_irq_threshold_reg <= THRESH_RESET;
			ook_floor_level_reg <= FLOOR_RESET;
			irq_source_config_register_reg <= 8'h00;
			demodulation_config_register_reg <= DEMOD_RESET;
			ook_config_register_reg <= OOK_RESET;
		end else if (ce) begin
			if (wr_dev) deviation_setting_reg <= reg_wdata;
			if (wr_thr) signal_level_irq_threshold_reg <= reg_wdata;
			if (wr_flr) ook_floor_level_reg <= reg_wdata;
			if (wr_src) irq_source_config_register_reg <= reg_wdata;
			if (wr_dmd) demodulation_config_register_reg <= reg_wdata;
			if (wr_ook) ook_config_register_reg <= reg_wdata;
		end
	end

	// ****************************************
	// level estimation
	// ****************************************
	function automatic logic [7:0] rod_abs(input logic [7:0] v);
		rod_abs = v[7] ? 8'(-v) : v;
	endfunction : rod_abs

	wire logic [8:0] mag_sum = 9'(rod_abs(i_s2_reg)) + 9'(rod_abs(q_s2_reg));
	wire logic [7:0] mag = mag_sum[8] ? 8'hFF : mag_sum[7:0];

	rod_level_if lv ();
	logic sample_stb;

	rod_sample_gen u_gen (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.deviation(deviation_value),
		.stb(sample_stb)
	);
	assign lv.sample_stb = sample_stb;

	rod_level_est u_est (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.mag(mag),
		.lv(lv)
	);

	wire logic [7:0] signal_level_value = signal_level_readout_reg;

	// ****************************************
	// level interrupt
	// ****************************************
	wire logic above = signal_level_value > signal_level_irq_limit;
	wire logic clr_flag = wr_flag && reg_wdata[FLAG_BIT];

	always_ff @(posedge clk) begin
		if (rst) begin
			signal_level_readout_reg <= 8'h00;
			signal_level_irq_flag_reg <= 1'b0;
		end else if (ce) begin
			if (lv.level_stb) signal_level_readout_reg <= lv.level;
			if (above) signal_level_irq_flag_reg <= 1'b1;
			else if (clr_flag) signal_level_irq_flag_reg <= 1'b0;
		end
	end

	wire logic pin0_next = first_pin_rx_source_sel == SRC_LEVEL &&
		signal_level_irq_flag_reg;
	wire logic pin1_next = second_pin_rx_source_sel == SRC_LEVEL &&
		signal_level_irq_flag_reg;

	// ****************************************
	// ook threshold
	// ****************************************
	logic [7:0] peak_reg;
	logic [7:0] avg_reg;
	logic [7:0] chip_cnt_reg;
	logic [7:0] dec_cnt_reg;

	wire logic [7:0] dec_interval = ook_decay_period[2] ?
		8'(CHIP_SAMPLES >> (3'(ook_decay_period[1:0]) + 3'h1)) :
		8'(CHIP_SAMPLES << ook_decay_period[1:0]);
	wire logic dec_tick = lv.level_stb &&
		dec_cnt_reg + 8'h01 >= dec_interval;
	wire logic [7:0] peak_th = rod_sat_sub(peak_reg, PEAK_DROP);
	wire logic [7:0] active_th =
		ook_threshold_type == ROD_TH_FIXED ? floor_threshold_value :
		ook_threshold_type == ROD_TH_AVG ? avg_reg :
		(peak_th > floor_threshold_value ? peak_th : floor_threshold_value);
	wire logic [7:0] decayed = rod_sat_sub(peak_reg, rod_step(ook_decay_step));
	wire logic [7:0] decay_next =
		decayed > floor_threshold_value ? decayed : floor_threshold_value;
	wire logic ook_next = signal_level_value > active_th;
	wire logic [8:0] avg_sum = 9'(avg_reg) + 9'(signal_level_value);

	always_ff @(posedge clk) begin
		if (rst) begin
			peak_reg <= 8'h00;
			avg_reg <= 8'h00;
			dec_cnt_reg <= 8'h00;
			chip_cnt_reg <= 8'h00;
		end else if (ce && lv.level_stb) begin
			avg_reg <= avg_sum[8:1];
			chip_cnt_reg <= chip_cnt_reg + 8'h01;
			dec_cnt_reg <= dec_tick ? 8'h00 : dec_cnt_reg + 8'h01;
			if (signal_level_value > peak_reg) peak_reg <= signal_level_value;
			else if (dec_tick && !ook_next) peak_reg <= decay_next;
		end
	end

	// ****************************************
	// fsk phase demodulator
	// ****************************************
	logic i_prev_reg;
	// q sign at i rising edge
	wire logic i_rise = i_s2_reg[7] == 1'b0 && i_prev_reg;
	always_ff @(posedge clk) begin
		if (rst) i_prev_reg <= 1'b0;
		else if (ce) i_prev_reg <= i_s2_reg[7];
	end

	// ****************************************
	// outputs
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			first_interrupt_pin <= 1'b0;
			second_interrupt_pin <= 1'b0;
			ook_data <= 1'b0;
			fsk_raw_data <= 1'b0;
			reg_rdata <= 8'h00;
		end else if (ce) begin
			first_interrupt_pin <= pin0_next;
			second_interrupt_pin <= pin1_next;
			ook_data <= !fsk_mode && ook_next;
			if (fsk_mode && i_rise) fsk_raw_data <= !q_s2_reg[7];
			if (reg_rd) begin
				case (reg_addr)
					ADDR_READOUT: reg_rdata <= signal_level_value;
					ADDR_DEVIATION: reg_rdata <= deviation_setting_reg;
					ADDR_IRQ_THRESH: reg_rdata <= signal_level_irq_threshold_reg;
					ADDR_FLOOR: reg_rdata <= ook_floor_level_reg;
					ADDR_IRQ_FLAG: reg_rdata <= 8'({signal_level_irq_flag_reg, 2'b00});
					ADDR_IRQ_SRC: reg_rdata <= irq_source_config_register_reg;
					ADDR_DEMOD: reg_rdata <= demodulation_config_register_reg;
					ADDR_OOK_CFG: reg_rdata <= ook_config_register_reg;
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule : rod_top
`default_nettype wire

// File: testbench/rod_top_properties.sv
// rod_top_properties: port-level checks for rod_top
`timescale 1ns/1ps
`default_nettype none
module rod_top_properties
	import rod_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] i_in,
	input wire logic [7:0] q_in,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic first_interrupt_pin,
	input wire logic second_interrupt_pin,
	input wire logic ook_data,
	input wire logic fsk_raw_data
);
	// ****************
	// register shadow
	// ****************
	logic [7:0] sh [8];
	wire rd_ok = reg_rd && ce;
	wire clr = reg_wr && ce && reg_addr == ADDR_IRQ_FLAG
		&& reg_wdata[FLAG_BIT];
	wire [1:0] s0 = sh[5][SRC0_LSB+:2];
	wire [1:0] s1 = sh[5][SRC1_LSB+:2];
	always_ff @(posedge clk) begin
		if (rst) begin
			sh <= '{default: 8'h00};
			sh[1] <= DEV_RESET;
			sh[3] <= FLOOR_RESET;
		end else if (reg_wr && ce && !reg_addr[3]) begin
			sh[reg_addr[2:0]] <= reg_wdata;
		end
	end
	// ****************
	// properties
	// ****************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_hold;
		!rd_ok |=> $stable(reg_rdata);
	endproperty
	a_hold: assert property (p_hold)
		else $error("read data moved without a read");
	property p_unmap;
		rd_ok && reg_addr[3] |=> reg_rdata == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped read not zero");
	property p_back;
		rd_ok && !reg_addr[3] && reg_addr[1:0] != 2'h0
			|=> reg_rdata == sh[$past(reg_addr[2:0])];
	endproperty
	a_back: assert property (p_back)
		else $error("register readback differs");
	property p_src0;
		(s0 != SRC_LEVEL) [*2] |-> !first_interrupt_pin;
	endproperty
	a_src0: assert property (p_src0)
		else $error("first pin high while not selected");
	property p_src1;
		s1 != SRC_LEVEL && $past(s1) != SRC_LEVEL |-> !second_interrupt_pin;
	endproperty
	a_src1: assert property (p_src1)
		else $error("second pin high while not selected");
	property p_sticky;
		first_interrupt_pin && s0 == SRC_LEVEL && !clr && !$past(clr)
			|=> first_interrupt_pin;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("level flag dropped without a clear");
	property p_fsk;
		sh[6][FSK_BIT] && $past(sh[6][FSK_BIT]) |-> !ook_data;
	endproperty
	a_fsk: assert property (p_fsk)
		else $error("ook data high in fsk mode");
	property p_rst;
		$fell(rst) |-> !first_interrupt_pin && !second_interrupt_pin
			&& !ook_data && reg_rdata == 8'h00;
	endproperty
	a_rst: assert property (p_rst)
		else $error("outputs not cleared by reset");
	property p_ce;
		!ce |=> $stable(first_interrupt_pin) && $stable(ook_data);
	endproperty
	a_ce: assert property (p_ce)
		else $error("outputs moved while frozen");
	c_pin: cover property (first_interrupt_pin);
	c_ook: cover property (ook_data ##1 !ook_data);
	c_fsk: cover property (fsk_raw_data);
endmodule : rod_top_properties
bind rod_top rod_top_properties u_props (.clk(clk), .rst(rst), .ce(ce),
	.i_in(i_in), .q_in(q_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.first_interrupt_pin(first_interrupt_pin),
	.second_interrupt_pin(second_interrupt_pin), .ook_data(ook_data),
	.fsk_raw_data(fsk_raw_data));
`default_nettype wire

// File: testbench/rod_if_model.sv
// rod_if_model: quadrature baseband source standing in for the if chain
`timescale 1ns/1ps
`default_nettype none
module rod_if_model (
	input wire logic clk,
	input wire logic [7:0] amp,
	input wire logic dir,
	output logic [7:0] i_in,
	output logic [7:0] q_in
);
	// ****************
	// slow square-wave rotation, direction sets polarity
	// ****************
	logic [6:0] ph = 7'h00;
	always @(posedge clk) begin
		ph <= dir ? ph - 7'h01 : ph + 7'h01;
	end
	assign i_in = ph[6] ? 8'h00 - amp : amp;
	assign q_in = (ph[6] ^ ph[5]) ? 8'h00 - amp : amp;
endmodule : rod_if_model
`default_nettype wire

// File: testbench/test_rssi_ook_threshold_demod.sv
// test_rssi_ook_threshold_demod: self-checking bench for rod_top
`timescale 1ns/1ps
`default_nettype none
module test_rssi_ook_threshold_demod import rod_pkg::*;;
	logic clk, rst, ce, wr, rd, dir, p1, p2, ook, fsk;
	logic [3:0] addr;
	logic [7:0] wdata, amp, rdata, v;
	wire [7:0] i_in, q_in;
	int fails = 0;
	int cmp_count = 0;
	logic [7:0] rv [8] = '{8'h00, DEV_RESET, THRESH_RESET, FLOOR_RESET,
		8'h00, 8'h00, DEMOD_RESET, OOK_RESET};
	rod_if_model u_if (.clk(clk), .amp(amp), .dir(dir), .i_in(i_in),
		.q_in(q_in));
	rod_top dut (.clk(clk), .rst(rst), .ce(ce), .i_in(i_in), .q_in(q_in),
		.reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdata), .first_interrupt_pin(p1),
		.second_interrupt_pin(p2), .ook_data(ook), .fsk_raw_data(fsk));
	// ****************
	// helpers
	// ****************
	function automatic logic [7:0] lvl(input logic [7:0] a);
		lvl = {a[6:0], 1'b0};
	endfunction : lvl
	function automatic logic above(input logic [7:0] l, input logic [7:0] t);
		above = l > t;
	endfunction : above
	task automatic chk_reg(input string n, input logic [7:0] e,
		input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask : chk_reg
	task automatic chk_pin(input string n, input logic e, input logic g);
		chk_reg(n, {7'h00, e}, {7'h00, g});
	endtask : chk_pin
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask : idle
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask : wreg
	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		chk_reg("reg_rdata", e, rdata);
	endtask : rchk
	task automatic conclude();
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude
	// ****************
	// stimulus
	// ****************
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		conclude();
	end
	initial begin
		{rst, ce, wr, rd, dir, addr, wdata, amp} = {2'h3, 3'h0, 20'h00000};
		void'($urandom(47));
		idle(5);
		rst = 1'b0;
		for (int k = 1; k < 8; k++) begin
			rchk(4'(k), rv[k]);
		end
		wreg(ADDR_READOUT, 8'h55);
		rchk(ADDR_READOUT, 8'h00);
		wreg(4'h9, 8'hAA);
		rchk(4'h9, 8'h00);
		for (int k = 1; k < 8; k++) begin
			v = 8'($urandom());
			if (k != 4) begin
				wreg(4'(k), v);
				rchk(4'(k), v);
			end
		end
		wreg(ADDR_DEMOD, 8'h00);
		wreg(ADDR_FLOOR, 8'h00);
		wreg(ADDR_IRQ_SRC, 8'h00);
		// deviation sets the level sampling rate
		wreg(ADDR_DEVIATION, 8'hFF);
		wreg(ADDR_IRQ_THRESH, 8'hFF);
		repeat (3) begin
			amp = 8'($urandom_range(60, 1));
			ce = 1'b0;
			idle(4);
			ce = 1'b1;
			idle(400);
			rchk(ADDR_READOUT, lvl(amp));
		end
		wreg(ADDR_IRQ_FLAG, 8'h04);
		wreg(ADDR_IRQ_THRESH, lvl(amp));
		wreg(ADDR_IRQ_SRC, 8'h40);
		idle(20);
		rchk(ADDR_IRQ_FLAG, 8'h00);
		wreg(ADDR_IRQ_THRESH, lvl(amp) - 8'h01);
		idle(4);
		rchk(ADDR_IRQ_FLAG, 8'h04);
		chk_pin("first_pin", 1'b1, p1);
		wreg(ADDR_IRQ_SRC, 8'h10);
		idle(2);
		chk_pin("second_pin", 1'b1, p2);
		chk_pin("first_pin", 1'b0, p1);
		wreg(ADDR_IRQ_SRC, 8'hA0);
		idle(2);
		chk_pin("second_pin", 1'b0, p2);
		wreg(ADDR_IRQ_SRC, 8'h40);
		wreg(ADDR_OOK_CFG, 8'hFC);
		amp = 8'h00;
		idle(400);
		rchk(ADDR_IRQ_FLAG, 8'h04);
		wreg(ADDR_IRQ_FLAG, 8'h04);
		idle(2);
		rchk(ADDR_IRQ_FLAG, 8'h00);
		chk_pin("first_pin", 1'b0, p1);
		amp = 8'h32;
		wreg(ADDR_DEMOD, 8'h08);
		wreg(ADDR_FLOOR, 8'h60);
		idle(400);
		chk_pin("ook_data", above(lvl(amp), 8'h60), ook);
		wreg(ADDR_FLOOR, 8'h68);
		idle(3);
		chk_pin("ook_data", above(lvl(amp), 8'h68), ook);
		wreg(ADDR_FLOOR, 8'h00);
		wreg(ADDR_OOK_CFG, 8'h0C);
		wreg(ADDR_DEMOD, 8'h00);
		idle(40);
		chk_pin("ook_data", above(lvl(amp), lvl(amp) - PEAK_DROP), ook);
		v = lvl(amp) - PEAK_DROP;
		amp = 8'h28;
		idle(400);
		chk_pin("ook_data", above(lvl(amp), v), ook);
		wreg(ADDR_FLOOR, 8'h5A);
		wreg(ADDR_OOK_CFG, 8'hFC);
		idle(400);
		chk_pin("ook_data", above(lvl(amp), 8'h5A), ook);
		wreg(ADDR_FLOOR, 8'h00);
		idle(400);
		chk_pin("ook_data", 1'b1, ook);
		wreg(ADDR_DEMOD, 8'h20);
		for (int k = 0; k < 2; k++) begin
			dir = k[0];
			idle(300);
			chk_pin("fsk_raw_data", ~dir, fsk);
			chk_pin("ook_data", 1'b0, ook);
		end
		conclude();
	end
endmodule : test_rssi_ook_threshold_demod
`default_nettype wire
